// [rtl/pcdos_pkg.sv]
// pcdos_pkg: constants shared by the digital offset select block and its fifo
// assumes: register index map on a 32-bit apb word grid, byte address = 4 * index
package pcdos_pkg;
   // ----------------------------------------------------------------
   // widths and sizes
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 16;
   localparam int OFF_W = 7;
   localparam int NUM_COLORS = 5;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_CNT_W = 6;
   localparam int IDX_W = 8;
   localparam int READY_MARGIN = 3;
   // ----------------------------------------------------------------
   // register indices (byte address is four times these)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_COLOR1 = 8'h0f;
   localparam logic [7:0] IDX_COLOR2 = 8'h10;
   localparam logic [7:0] IDX_COLOR3 = 8'h11;
   localparam logic [7:0] IDX_COLOR4 = 8'h12;
   localparam logic [7:0] IDX_COLOR5 = 8'h13;
   localparam logic [7:0] IDX_CTRL = 8'h20;
   localparam logic [7:0] IDX_STATUS = 8'h21;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] OFF_RESET = 7'h40;
   localparam logic [6:0] OFF_MIDSCALE = 7'h40;
   localparam logic CTRL_RESET_MODE = 1'b0;
   localparam int CTRL_MODE_BIT = 0;
   localparam int STAT_SAT_BIT = 0;
   localparam int STAT_CNT_LSB = 8;
   // ----------------------------------------------------------------
   // stream tags
   // ----------------------------------------------------------------
   localparam logic [1:0] CHAN_RED = 2'h0;
   localparam logic [1:0] CHAN_GREEN = 2'h1;
   localparam logic [1:0] CHAN_BLUE = 2'h2;
   localparam logic [2:0] LINE_C1 = 3'h0;
   localparam logic [2:0] LINE_C2 = 3'h1;
   localparam logic [2:0] LINE_C3 = 3'h2;
   localparam logic [2:0] LINE_C4 = 3'h3;
   localparam logic [2:0] LINE_C5 = 3'h4;
endpackage

// [rtl/pcdos_fifo.sv]
// pcdos_fifo: flop-based synchronous fifo with valid/ready on both sides
// assumes: one clock, depth a power of two, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pcdos_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   localparam int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   // fill level
   output logic [AW:0] count_o
);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;
   logic push_w;
   logic pop_w;

   // honest flags straight from the level counter
   assign in_ready_o = (count_r != FULL);
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rptr_r];
   assign count_o = count_r;
   assign push_w = in_valid_i && in_ready_o;
   assign pop_w = out_valid_o && out_ready_i;

   // storage, written by index
   always_ff @(posedge clock_i)
   begin
      if (push_w)
      begin
         mem_r[wptr_r] <= in_data_i;
      end
   end

   // pointers and level
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push_w)
         begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop_w)
         begin
            rptr_r <= rptr_r + 1'b1;
         end
         if (push_w && !pop_w)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop_w && !push_w)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/pcdos_top.sv]
// pcdos_top: per-color digital offset select and apply on the adc sample stream
// assumes: samples, tags and line color come from logic on clock_i; apb on clock_i
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - per-line mode: second color lines use the second color offset register
// - per-line mode: third color lines use the third color offset register
// - fixed channel modes: red input uses the first color offset register
// - fixed modes: green uses second register, blue uses third register
// - every offset field is read as offset-binary code
// - offset registers are 8 bits, bit 7 unused, second resets to 0x40
// - a fourth color offset register of the same layout exists
// - per-line mode: first color lines use the first color offset register
// - per-line mode: fourth color lines use the fourth color offset register
// - per-line mode uses fifth register on fifth lines; fixed modes ignore it
module pcdos_top
   import pcdos_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // adc sample stream in
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   input wire logic [1:0] sample_chan_i,
   input wire logic [2:0] line_color_i,
   output logic sample_ready_o,
   // corrected sample stream out
   output logic [SAMPLE_W-1:0] out_sample_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [OFF_W-1:0] color_off_r [NUM_COLORS];
   logic mode_r;
   logic sat_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_val;
   logic [IDX_W-1:0] idx_w;
   logic aligned_w;
   logic mapped_w;
   logic setup_w;
   logic wr_w;
   logic sample_ready_r;
   logic acc_w;
   logic [OFF_W-1:0] sel_code;
   logic [SAMPLE_W+1:0] sum_w;
   logic [SAMPLE_W-1:0] corr_w;
   logic sat_w;
   logic s1_valid_r;
   logic [SAMPLE_W-1:0] s1_data_r;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [SAMPLE_W-1:0] fifo_out_data;
   logic [FIFO_CNT_W-1:0] fifo_count;
   logic out_valid_r;
   logic [SAMPLE_W-1:0] out_sample_r;
   genvar gi;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // word index; upper and lower address bits must be clear to hit
   assign idx_w = paddr_i[9:2];
   assign aligned_w = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
   assign setup_w = psel_i && !penable_i;
   assign wr_w = psel_i && penable_i && pready_r && pwrite_i && aligned_w;

   // read mux; unused bits above the field read as zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      mapped_w = 1'b0;
      for (int i = 0; i < NUM_COLORS; i++)
      begin
         if (idx_w == IDX_COLOR1 + IDX_W'(i))
         begin
            rd_val = {{(32-OFF_W){1'b0}}, color_off_r[i]};
            mapped_w = 1'b1;
         end
      end
      if (idx_w == IDX_CTRL)
      begin
         rd_val[CTRL_MODE_BIT] = mode_r;
         mapped_w = 1'b1;
      end
      if (idx_w == IDX_STATUS)
      begin
         rd_val[STAT_SAT_BIT] = sat_r;
         rd_val[STAT_CNT_LSB +: FIFO_CNT_W] = fifo_count;
         mapped_w = 1'b1;
      end
      mapped_w = mapped_w && aligned_w;
   end

   // answer registered from the setup cycle: access phase is always one cycle
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup_w;
         pslverr_r <= setup_w && !mapped_w;
         prdata_r <= (setup_w && !pwrite_i && mapped_w) ? rd_val : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // one offset register per color, low byte lane only, bit 7 not stored
   generate
      for (gi = 0; gi < NUM_COLORS; gi++)
      begin : g_color
         always_ff @(posedge clock_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               color_off_r[gi] <= OFF_RESET;
            end
            else if (wr_w && pstrb_i[0] && (idx_w == IDX_COLOR1 + IDX_W'(gi)))
            begin
               color_off_r[gi] <= pwdata_i[OFF_W-1:0];
            end
         end
      end
   endgenerate

   // mode control: 1 selects per-line colors, 0 the fixed three-channel modes
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_r <= CTRL_RESET_MODE;
      end
      else if (wr_w && pstrb_i[0] && (idx_w == IDX_CTRL))
      begin
         mode_r <= pwdata_i[CTRL_MODE_BIT];
      end
   end

   // sticky saturation flag, write one to clear; a new hit beats the clear
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sat_r <= 1'b0;
      end
      else if (acc_w && sat_w)
      begin
         sat_r <= 1'b1;
      end
      else if (wr_w && pstrb_i[0] && (idx_w == IDX_STATUS) && pwdata_i[STAT_SAT_BIT])
      begin
         sat_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // offset select and apply
   // ----------------------------------------------------------------
   assign acc_w = sample_valid_i && sample_ready_r;

   // register choice; an unknown tag or line gets midscale, i.e. no correction
   always_comb
   begin
      sel_code = OFF_MIDSCALE;
      if (mode_r)
      begin
         case (line_color_i)
            LINE_C1: sel_code = color_off_r[0];
            LINE_C2: sel_code = color_off_r[1];
            LINE_C3: sel_code = color_off_r[2];
            LINE_C4: sel_code = color_off_r[3];
            LINE_C5: sel_code = color_off_r[4];
            default: sel_code = OFF_MIDSCALE;
         endcase
      end
      else
      begin
         // fifth register has no channel here, so it never takes effect
         case (sample_chan_i)
            CHAN_RED: sel_code = color_off_r[0];
            CHAN_GREEN: sel_code = color_off_r[1];
            CHAN_BLUE: sel_code = color_off_r[2];
            default: sel_code = OFF_MIDSCALE;
         endcase
      end
   end

   // offset-binary: subtract midscale, add, clamp into the unsigned word
   always_comb
   begin
      sum_w = {2'b00, sample_i} + (SAMPLE_W+2)'(sel_code)
         - (SAMPLE_W+2)'(OFF_MIDSCALE);
      sat_w = 1'b0;
      corr_w = sum_w[SAMPLE_W-1:0];
      if (sum_w[SAMPLE_W+1])
      begin
         corr_w = '0;
         sat_w = 1'b1;
      end
      else if (sum_w[SAMPLE_W])
      begin
         corr_w = '1;
         sat_w = 1'b1;
      end
   end

   // result stage; the ready margin keeps it from ever meeting a full fifo
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s1_valid_r <= 1'b0;
         s1_data_r <= '0;
      end
      else if (acc_w)
      begin
         s1_valid_r <= 1'b1;
         s1_data_r <= corr_w;
      end
      else if (fifo_in_ready)
      begin
         s1_valid_r <= 1'b0;
      end
   end

   // registered ready, so back-pressure lags by a cycle; margin covers it
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sample_ready_r <= 1'b0;
      end
      else
      begin
         sample_ready_r <= (fifo_count <= FIFO_CNT_W'(FIFO_DEPTH - READY_MARGIN));
      end
   end

   // ----------------------------------------------------------------
   // buffering and output stage
   // ----------------------------------------------------------------
   pcdos_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .in_data_i(s1_data_r),
      .in_valid_i(s1_valid_r),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .count_o(fifo_count)
   );

   assign fifo_out_ready = !out_valid_r || out_ready_i;

   // output register, refilled whenever it empties or is taken
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         out_valid_r <= 1'b0;
         out_sample_r <= '0;
      end
      else if (fifo_out_ready)
      begin
         out_valid_r <= fifo_out_valid;
         if (fifo_out_valid)
         begin
            out_sample_r <= fifo_out_data;
         end
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign sample_ready_o = sample_ready_r;
   assign out_sample_o = out_sample_r;
   assign out_valid_o = out_valid_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // independent integer reference for the corrected value
   function automatic logic [SAMPLE_W-1:0] ref_apply(logic [SAMPLE_W-1:0] s,
      logic [OFF_W-1:0] c);
      int v;
      v = int'(s) + int'(c) - int'(OFF_MIDSCALE);
      if (v < 0)
      begin
         v = 0;
      end
      if (v > (1 << SAMPLE_W) - 1)
      begin
         v = (1 << SAMPLE_W) - 1;
      end
      return SAMPLE_W'(v);
   endfunction

   sequence s_take_line(logic [2:0] code);
      acc_w && mode_r && (line_color_i == code);
   endsequence

   sequence s_take_chan(logic [1:0] code);
      acc_w && !mode_r && (sample_chan_i == code);
   endsequence

   property p_line_c1;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_line(LINE_C1) |=> s1_valid_r
         && s1_data_r == ref_apply($past(sample_i), $past(color_off_r[0]));
   endproperty
   a_line_c1: assert property (p_line_c1) else $error("color 1 line offset wrong");

   property p_line_c2;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_line(LINE_C2) |=> s1_valid_r
         && s1_data_r == ref_apply($past(sample_i), $past(color_off_r[1]));
   endproperty
   a_line_c2: assert property (p_line_c2) else $error("color 2 line offset wrong");

   property p_line_c3;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_line(LINE_C3) |=> s1_data_r == ref_apply($past(sample_i), $past(color_off_r[2]));
   endproperty
   a_line_c3: assert property (p_line_c3) else $error("color 3 line offset wrong");

   property p_line_c4;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_line(LINE_C4) |=> s1_data_r == ref_apply($past(sample_i), $past(color_off_r[3]));
   endproperty
   a_line_c4: assert property (p_line_c4) else $error("color 4 line offset wrong");

   property p_line_c5;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_line(LINE_C5) |=> s1_data_r == ref_apply($past(sample_i), $past(color_off_r[4]));
   endproperty
   a_line_c5: assert property (p_line_c5) else $error("color 5 line offset wrong");

   property p_chan_red;
      @(posedge clock_i) disable iff (!rstn_i)
      s_take_chan(CHAN_RED) |=> s1_data_r == ref_apply($past(sample_i), $past(color_off_r[0]));
   endproperty
   a_chan_red: assert property (p_chan_red) else $error("red input offset wrong");

   property p_chan_green_blue;
      @(posedge clock_i) disable iff (!rstn_i)
      (s_take_chan(CHAN_GREEN) |=> s1_data_r
         == ref_apply($past(sample_i), $past(color_off_r[1])))
      and (s_take_chan(CHAN_BLUE) |=> s1_data_r
         == ref_apply($past(sample_i), $past(color_off_r[2])));
   endproperty
   a_chan_green_blue: assert property (p_chan_green_blue) else $error("g/b offset wrong");

   property p_midscale_neutral;
      @(posedge clock_i) disable iff (!rstn_i)
      acc_w && (sel_code == OFF_MIDSCALE) |=> s1_data_r == $past(sample_i);
   endproperty
   a_midscale_neutral: assert property (p_midscale_neutral) else $error("midscale moved");

   property p_floor_sat;
      @(posedge clock_i) disable iff (!rstn_i)
      acc_w && ((17'(sample_i) + 17'(sel_code)) < 17'(OFF_MIDSCALE))
         |=> s1_data_r == '0 && sat_r;
   endproperty
   a_floor_sat: assert property (p_floor_sat) else $error("no clamp at zero");

   property p_reg_read_width;
      @(posedge clock_i) disable iff (!rstn_i)
      setup_w && !pwrite_i && aligned_w && (idx_w == IDX_COLOR2)
         |=> pready_r && !pslverr_r && prdata_r[31:OFF_W] == '0
         && prdata_r[OFF_W-1:0] == $past(color_off_r[1]);
   endproperty
   a_reg_read_width: assert property (p_reg_read_width) else $error("color 2 read bad");

   property p_c4_write;
      @(posedge clock_i) disable iff (!rstn_i)
      wr_w && pstrb_i[0] && (idx_w == IDX_COLOR4)
         |=> color_off_r[3] == $past(pwdata_i[OFF_W-1:0]);
   endproperty
   a_c4_write: assert property (p_c4_write) else $error("color 4 write lost");
endmodule
`default_nettype wire

// [testbench/pcdos_top_tb.sv]
// pcdos_top_tb: self-checking bench for the digital offset select block
// assumes: pcdos_pkg compiled first; apb and sample stream share clock_i
`timescale 1ns/1ps
`default_nettype none
module pcdos_top_tb
   import pcdos_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and observation signals
   // ----------------------------------------------------------------
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [3:0] pstrb_i = 4'hf;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic [15:0] sample_i = 16'h0000;
   logic sample_valid_i = 1'b0;
   logic [1:0] sample_chan_i = 2'h0;
   logic [2:0] line_color_i = 3'h0;
   logic sample_ready_o;
   logic [15:0] out_sample_o;
   logic out_valid_o;
   logic out_ready_i = 1'b1;
   int failures = 0;
   int num_checks = 0;
   logic [15:0] exp_q[$];
   logic [3:0] strb = 4'hf;
   pcdos_top DUT (
      .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .sample_chan_i(sample_chan_i), .line_color_i(line_color_i),
      .sample_ready_o(sample_ready_o), .out_sample_o(out_sample_o),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready_i)
   );
   // 100 ns period
   always #50 clock_i = ~clock_i;
   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up(input string what);
      failures++;
      $display("[FAIL] %0t wait for %s ran out, got %h expected %h", $time, what, 0, 1);
      tally_and_finish();
   endtask
   // byte address is four times the register index
   function automatic logic [11:0] ra(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   // the correction the stream must show: code minus midscale, clamped
   function automatic logic [15:0] corr(input logic [15:0] s, input logic [6:0] code);
      int v;
      v = int'(s) + int'(code) - 64;
      if (v < 0) v = 0;
      if (v > 65535) v = 65535;
      return v[15:0];
   endfunction
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clock_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= strb;
      @(posedge clock_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) give_up("pready");
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check(rd, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask
   // valid stays up between back-to-back sends; stream_idle drops it
   task automatic send(input logic [15:0] s, input logic [1:0] ch, input logic [2:0] ln,
                       input int bound, output logic taken);
      int n;
      sample_i <= s;
      sample_chan_i <= ch;
      line_color_i <= ln;
      sample_valid_i <= 1'b1;
      taken = 1'b0;
      n = 0;
      while (!taken && n < bound)
      begin
         @(posedge clock_i);
         n++;
         if (sample_ready_o === 1'b1) taken = 1'b1;
      end
   endtask
   task automatic push(input logic [15:0] s, input logic [1:0] ch, input logic [2:0] ln,
                       input logic [15:0] e);
      logic taken;
      send(s, ch, ln, 50, taken);
      if (!taken) give_up("sample_ready");
      exp_q.push_back(e);
   endtask
   task automatic stream_idle();
      sample_valid_i <= 1'b0;
      @(posedge clock_i);
   endtask
   // drain with an optional stalling consumer
   task automatic drain(input logic stall);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 400)
      begin
         if (stall) out_ready_i <= ~out_ready_i;
         @(posedge clock_i);
         n++;
      end
      out_ready_i <= 1'b1;
      if (n >= 400) give_up("stream output");
   endtask
   // scoreboard: every output taken is compared in order
   always @(posedge clock_i)
   begin
      if (rstn_i === 1'b1 && out_valid_o === 1'b1 && out_ready_i === 1'b1)
      begin
         if (exp_q.size() == 0) check({16'h0, out_sample_o}, 32'hffff_ffff);
         else check({16'h0, out_sample_o}, {16'h0, exp_q.pop_front()});
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] idx[5] = '{IDX_COLOR1, IDX_COLOR2, IDX_COLOR3, IDX_COLOR4, IDX_COLOR5};
      foreach (idx[i]) rd_chk(ra(idx[i]), 32'h0000_0040, 1'b0);
      rd_chk(ra(IDX_CTRL), 32'h0000_0000, 1'b0);
      wr(ra(IDX_COLOR2), 32'hffff_ffff);
      rd_chk(ra(IDX_COLOR2), 32'h0000_007f, 1'b0);
      wr(ra(IDX_COLOR4), 32'h0000_00a5);
      rd_chk(ra(IDX_COLOR4), 32'h0000_0025, 1'b0);
      strb = 4'h0;
      wr(ra(IDX_COLOR3), 32'h0000_0011);
      strb = 4'hf;
      rd_chk(ra(IDX_COLOR3), 32'h0000_0040, 1'b0);
      rd_chk(ra(8'hff), 32'h0000_0000, 1'b1);
      rd_chk(12'h041, 32'h0000_0000, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_fixed();
      wr(ra(IDX_COLOR1), 32'h0000_0050);
      wr(ra(IDX_COLOR2), 32'h0000_0030);
      wr(ra(IDX_COLOR3), 32'h0000_0041);
      wr(ra(IDX_COLOR5), 32'h0000_0000);
      @(posedge clock_i);
      // line tag points at color 5 to show it is ignored here
      push(16'h1000, CHAN_RED, LINE_C5, corr(16'h1000, 7'h50));
      push(16'h1000, CHAN_GREEN, LINE_C5, corr(16'h1000, 7'h30));
      push(16'h1000, CHAN_BLUE, LINE_C5, corr(16'h1000, 7'h41));
      push(16'h1000, 2'h3, LINE_C5, 16'h1000);
      stream_idle();
      drain(1'b0);
      $display("test fixed done");
   endtask
   task automatic t_line();
      logic [6:0] code[5] = '{7'h50, 7'h30, 7'h41, 7'h00, 7'h7f};
      wr(ra(IDX_CTRL), 32'h0000_0001);
      rd_chk(ra(IDX_CTRL), 32'h0000_0001, 1'b0);
      wr(ra(IDX_COLOR4), 32'h0000_0000);
      wr(ra(IDX_COLOR5), 32'h0000_007f);
      @(posedge clock_i);
      // channel tag held at red to show it is ignored here
      push(16'h2000, CHAN_RED, LINE_C1, corr(16'h2000, code[0]));
      push(16'h2000, CHAN_RED, LINE_C2, corr(16'h2000, code[1]));
      push(16'h2000, CHAN_RED, LINE_C3, corr(16'h2000, code[2]));
      push(16'h2000, CHAN_RED, LINE_C4, corr(16'h2000, code[3]));
      push(16'h2000, CHAN_RED, LINE_C5, corr(16'h2000, code[4]));
      push(16'h2000, CHAN_RED, 3'h5, 16'h2000);
      stream_idle();
      drain(1'b0);
      $display("test per-line done");
   endtask
   task automatic t_sat();
      rd_chk(ra(IDX_STATUS), 32'h0000_0000, 1'b0);
      @(posedge clock_i);
      push(16'hfff0, CHAN_RED, LINE_C5, 16'hffff);
      push(16'h0020, CHAN_RED, LINE_C4, 16'h0000);
      stream_idle();
      drain(1'b0);
      rd_chk(ra(IDX_STATUS), 32'h0000_0001, 1'b0);
      wr(ra(IDX_STATUS), 32'h0000_0001);
      rd_chk(ra(IDX_STATUS), 32'h0000_0000, 1'b0);
      $display("test saturation done");
   endtask
   task automatic t_fifo();
      int acc;
      logic taken;
      logic [31:0] rd;
      logic err;
      acc = 0;
      out_ready_i <= 1'b0;
      @(posedge clock_i);
      // fill with the consumer stalled until the block refuses
      for (int i = 0; i < 40; i++)
      begin
         send(16'h0100 + i[15:0], CHAN_RED, LINE_C3, 4, taken);
         if (!taken) break;
         exp_q.push_back(corr(16'h0100 + i[15:0], 7'h41));
         acc++;
      end
      stream_idle();
      check({31'h0, (acc >= 30 && acc <= 34)}, 32'h0000_0001);
      apb(1'b0, ra(IDX_STATUS), 32'h0000_0000, rd, err);
      check({31'h0, (rd[13:8] >= 6'd30)}, 32'h0000_0001);
      drain(1'b1);
      $display("test fifo done");
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clock_i);
      rstn_i <= 1'b1;
      t_regs();
      t_fixed();
      t_line();
      t_sat();
      t_fifo();
      repeat (5) @(posedge clock_i);
      tally_and_finish();
   end
endmodule
`default_nettype wire
